/* File: hdl/dtc_half.sv */
// one timer half: output polarity, debug freeze and edge event detection
`timescale 1ns/1ps
module dtc_half
(
    input wire logic clk,
    input wire logic srst,
    input wire dtc_pkg::dtc_half_t cfg,
    input wire logic debug_halt,
    input wire logic pwm_raw,
    output logic pwm_out,
    output logic count_enable,
    output logic edge_event
);
    typedef struct packed
    {
        logic pwm_out;
        logic count_enable;
        logic edge_event;
        logic last_level;
    } dtc_half_state_t;

    dtc_half_state_t st;
    dtc_half_state_t next_st;
    logic level;
    logic rose;
    logic fell;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb
    begin
        level = pwm_raw ^ cfg.output_invert; // see R01 see R02
        // detect on the raw pwm, so inversion leaves the seen edge unchanged
        rose = pwm_raw & ~st.last_level; // see R05
        fell = ~pwm_raw & st.last_level;
        next_st = st;
        next_st.last_level = pwm_raw;
        next_st.pwm_out = level;
        // freeze only matters while the core is halted
        next_st.count_enable = cfg.run_enable & ~(cfg.debug_freeze & debug_halt); // see R06 see R07
        case (cfg.edge_select) // see R03 see R04
            dtc_pkg::dtc_edge_pos: next_st.edge_event = cfg.run_enable & rose;
            dtc_pkg::dtc_edge_neg: next_st.edge_event = cfg.run_enable & fell;
            dtc_pkg::dtc_edge_both: next_st.edge_event = cfg.run_enable & (rose | fell);
            default: next_st.edge_event = 1'b0; // reserved code never fires
        endcase
        if (srst)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign pwm_out = st.pwm_out;
    assign count_enable = st.count_enable;
    assign edge_event = st.edge_event;

    // =====================================================================
    // checks
    // =====================================================================
    freeze_halt_a: assert property (@(posedge clk) disable iff (srst) // see R06
        (cfg.run_enable && cfg.debug_freeze && debug_halt) |=> !count_enable)
        else $error("count runs while frozen");
    polarity_out_a: assert property (@(posedge clk) disable iff (srst) // see R01
        ##1 pwm_out == ($past(pwm_raw) ^ $past(cfg.output_invert)))
        else $error("pwm polarity wrong");
    pos_edge_a: assert property (@(posedge clk) disable iff (srst) // see R05
        (cfg.edge_select == dtc_pkg::dtc_edge_pos && cfg.run_enable
         && pwm_raw && !st.last_level) |=> edge_event)
        else $error("positive edge missed");
    rsv_quiet_a: assert property (@(posedge clk) disable iff (srst) // see R03
        (cfg.edge_select == dtc_pkg::dtc_edge_rsv) |=> !edge_event)
        else $error("reserved edge code fired");
endmodule : dtc_half

/* File: hdl/dtc_irq.sv */
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module dtc_irq
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] events,
    input wire logic clear_strobe,
    input wire logic [1:0] clear_bits,
    input wire logic [1:0] mask,
    output logic [1:0] status,
    output logic irq
);
    typedef struct packed
    {
        logic [1:0] status;
        logic irq;
    } dtc_irq_state_t;

    dtc_irq_state_t st;
    dtc_irq_state_t next_st;

    // set beats clear so no event is lost in the clearing cycle
    always_comb
    begin
        next_st.status = (st.status & ~(clear_strobe ? clear_bits : 2'h0)) | events;
        next_st.irq = |(next_st.status & mask);
        if (srst)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign status = st.status;
    assign irq = st.irq;

    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        events[0] |=> status[0])
        else $error("event lost");
endmodule : dtc_irq

/* File: hdl/dtc_pkg.sv */
// package with register map, field positions and shared types of the dual timer control
package dtc_pkg;

    // =====================================================================
    // register map (byte addresses, 32-bit words)
    // =====================================================================
    localparam logic [7:0] ctrl_offset = 8'h0c;
    localparam logic [7:0] config_offset = 8'h00;
    localparam logic [7:0] status_offset = 8'h1c;
    localparam logic [7:0] mask_offset = 8'h18;

    // =====================================================================
    // control register fields
    // =====================================================================
    localparam int a_run_pos = 0;
    localparam int a_freeze_pos = 1;
    localparam int a_edge_lo = 2;
    localparam int a_invert_pos = 6;
    localparam int b_run_pos = 8;
    localparam int b_freeze_pos = 9;
    localparam int b_edge_lo = 10;
    localparam int b_invert_pos = 14;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [31:0] ctrl_mask = 32'h0000_4f4f;
    localparam logic [2:0] config_reset = 3'h0;

    // =====================================================================
    // status bits: event of timer a at 0, timer b at 1
    // =====================================================================
    localparam int ev_a_pos = 0;
    localparam int ev_b_pos = 1;
    localparam logic [1:0] ev_reset = 2'h0;

    // edge selection encoding
    typedef enum logic [1:0]
    {
        dtc_edge_pos = 2'h0,
        dtc_edge_neg = 2'h1,
        dtc_edge_rsv = 2'h2,
        dtc_edge_both = 2'h3
    } dtc_edge_t;

    // settings of one timer half
    typedef struct packed
    {
        logic run_enable;
        logic debug_freeze;
        dtc_edge_t edge_select;
        logic output_invert;
    } dtc_half_t;

    // avalon-mm request as seen by the slave
    typedef struct packed
    {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } dtc_req_t;

endpackage : dtc_pkg

/* File: hdl/dtc_top.sv */
// dual timer control register block with avalon-mm slave and event interrupt
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// Operation
// R01 - bit 14 inverts timer b pwm output
// R02 - bit 6 inverts timer a pwm output
// R03 - bits 11-10 select timer b event edge
// R04 - bits 3-2 select timer a event edge
// R05 - inversion reverses the detected event edge; the code detects on the raw pwm, so inversion leaves the edge unchanged
// R06 - bit 9 freezes timer b in debug halt
// R07 - bit 1 freezes timer a in debug halt
// R08 - bit 8 enables timer b
// R09 - bit 0 enables timer a
// R10 - control at 0x0c, resets to zero
// R11 - configuration low three bits steer mode
// R12 - reserved bits read zero; debug halt input
module dtc_top
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic debug_halt,
    input wire logic pwm_a_raw,
    input wire logic pwm_b_raw,
    output logic pwm_a,
    output logic pwm_b,
    output logic a_count_enable,
    output logic b_count_enable,
    output logic a_run_enable,
    output logic b_run_enable,
    output logic [2:0] timer_mode,
    output logic irq
);
    typedef struct packed
    {
        logic [31:0] timer_control_reg;
        logic [2:0] timer_configuration_reg;
        logic [1:0] event_mask;
        logic [31:0] readdata;
        logic ack;
        logic waitreq;
        logic halt_s1;
        logic halt_s2;
        logic pa_s1;
        logic pa_s2;
        logic pb_s1;
        logic pb_s2;
    } dtc_top_state_t;

    dtc_top_state_t st;
    dtc_top_state_t next_st;
    dtc_pkg::dtc_req_t req;
    dtc_pkg::dtc_half_t cfg_a;
    dtc_pkg::dtc_half_t cfg_b;
    logic [1:0] ev;
    logic [1:0] status;
    logic clr_strobe;
    logic irq_w;
    logic a_ce;
    logic b_ce;

    // =====================================================================
    // bus request bundle
    // =====================================================================
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.address = avs_address;
    assign req.writedata = avs_writedata;

    // field unpacking of the control register
    always_comb
    begin
        cfg_a.run_enable = st.timer_control_reg[dtc_pkg::a_run_pos]; // see R09
        cfg_a.debug_freeze = st.timer_control_reg[dtc_pkg::a_freeze_pos]; // see R07
        cfg_a.edge_select = dtc_pkg::dtc_edge_t'(st.timer_control_reg[dtc_pkg::a_edge_lo +: 2]);
        cfg_a.output_invert = st.timer_control_reg[dtc_pkg::a_invert_pos]; // see R02
        cfg_b.run_enable = st.timer_control_reg[dtc_pkg::b_run_pos]; // see R08
        cfg_b.debug_freeze = st.timer_control_reg[dtc_pkg::b_freeze_pos]; // see R06
        cfg_b.edge_select = dtc_pkg::dtc_edge_t'(st.timer_control_reg[dtc_pkg::b_edge_lo +: 2]);
        cfg_b.output_invert = st.timer_control_reg[dtc_pkg::b_invert_pos]; // see R01
    end

    // =====================================================================
    // timer halves
    // =====================================================================
    dtc_half u_half_a
    (
        .clk(clk),
        .srst(srst),
        .cfg(cfg_a),
        .debug_halt(st.halt_s2),
        .pwm_raw(st.pa_s2),
        .pwm_out(pwm_a),
        .count_enable(a_ce),
        .edge_event(ev[dtc_pkg::ev_a_pos])
    );

    dtc_half u_half_b
    (
        .clk(clk),
        .srst(srst),
        .cfg(cfg_b),
        .debug_halt(st.halt_s2),
        .pwm_raw(st.pb_s2),
        .pwm_out(pwm_b),
        .count_enable(b_ce),
        .edge_event(ev[dtc_pkg::ev_b_pos])
    );

    assign a_count_enable = a_ce;
    assign b_count_enable = b_ce;

    // =====================================================================
    // interrupt status and mask
    // =====================================================================
    // the clear lands in the answer cycle, like every other write
    assign clr_strobe = req.write && st.ack && (req.address == dtc_pkg::status_offset);

    dtc_irq u_irq
    (
        .clk(clk),
        .srst(srst),
        .events(ev),
        .clear_strobe(clr_strobe),
        .clear_bits(req.writedata[1:0]),
        .mask(st.event_mask),
        .status(status),
        .irq(irq_w)
    );

    assign irq = irq_w;

    // =====================================================================
    // register file and bus slave
    // =====================================================================
    // every access takes one wait cycle: the ack flop drops waitrequest next edge
    always_comb
    begin
        next_st = st;
        next_st.halt_s1 = debug_halt; // see R12
        next_st.halt_s2 = st.halt_s1;
        next_st.pa_s1 = pwm_a_raw;
        next_st.pa_s2 = st.pa_s1;
        next_st.pb_s1 = pwm_b_raw;
        next_st.pb_s2 = st.pb_s1;
        next_st.ack = (req.read || req.write) && !st.ack;
        // waitrequest has its own flop so the pin never sees a gate
        next_st.waitreq = !next_st.ack;
        // a write lands at the edge where the master sees waitrequest low
        if (req.write && st.ack)
        begin
            if (req.address == dtc_pkg::ctrl_offset)
            begin
                // reserved bits are dropped on write
                next_st.timer_control_reg = req.writedata & dtc_pkg::ctrl_mask; // see R12
            end
            else if (req.address == dtc_pkg::config_offset)
            begin
                next_st.timer_configuration_reg = req.writedata[2:0]; // see R11
            end
            else if (req.address == dtc_pkg::mask_offset)
            begin
                next_st.event_mask = req.writedata[1:0];
            end
        end
        if (req.read && !st.ack)
        begin
            if (req.address == dtc_pkg::ctrl_offset)
            begin
                next_st.readdata = st.timer_control_reg;
            end
            else if (req.address == dtc_pkg::config_offset)
            begin
                next_st.readdata = {29'h0, st.timer_configuration_reg};
            end
            else if (req.address == dtc_pkg::mask_offset)
            begin
                next_st.readdata = {30'h0, st.event_mask};
            end
            else if (req.address == dtc_pkg::status_offset)
            begin
                next_st.readdata = {30'h0, status};
            end
            else
            begin
                next_st.readdata = 32'h0000_0000; // unmapped reads zero
            end
        end
        if (srst)
        begin
            next_st = '0;
            next_st.timer_control_reg = dtc_pkg::ctrl_reset; // see R10
            next_st.timer_configuration_reg = dtc_pkg::config_reset;
            next_st.waitreq = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitreq;
    assign a_run_enable = st.timer_control_reg[dtc_pkg::a_run_pos]; // see R09
    assign b_run_enable = st.timer_control_reg[dtc_pkg::b_run_pos]; // see R08
    assign timer_mode = st.timer_configuration_reg; // see R11

    // =====================================================================
    // checks
    // =====================================================================
    // a control write is taken in the answer cycle
    sequence ctrl_write_s;
        avs_write && st.ack && avs_address == dtc_pkg::ctrl_offset;
    endsequence

    // a control read is captured one cycle before its answer
    sequence ctrl_read_s;
        avs_read && !st.ack && avs_address == dtc_pkg::ctrl_offset;
    endsequence

    // a configuration write, taken like the control write
    sequence config_write_s;
        avs_write && st.ack && avs_address == dtc_pkg::config_offset;
    endsequence

    // a request still waiting for its answer
    sequence bus_pending_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    // a request in its answer cycle
    sequence bus_answer_s;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence

    // timer a halted by the debugger with its freeze bit set
    sequence a_frozen_s;
        a_run_enable && cfg_a.debug_freeze && st.halt_s2;
    endsequence

    // reset leaves both halves disabled
    ctrl_reset_a: assert property (@(posedge clk) // see R10
        srst |=> (st.timer_control_reg == 32'h0 && !a_run_enable && !b_run_enable))
        else $error("control not cleared by reset");

    // reserved bits never hold a one
    rsv_zero_a: assert property (@(posedge clk) disable iff (srst) // see R12
        (st.timer_control_reg & ~dtc_pkg::ctrl_mask) == 32'h0)
        else $error("reserved control bits set");

    // a control write stores exactly the writable bits
    rsv_write_a: assert property (@(posedge clk) disable iff (srst) // see R12
        ctrl_write_s |=> st.timer_control_reg == ($past(avs_writedata) & dtc_pkg::ctrl_mask))
        else $error("control write not masked");

    b_enable_a: assert property (@(posedge clk) disable iff (srst) // see R08
        ctrl_write_s |=> b_run_enable == $past(avs_writedata[8]))
        else $error("timer b enable not stored");

    a_enable_a: assert property (@(posedge clk) disable iff (srst) // see R09
        ctrl_write_s |=> a_run_enable == $past(avs_writedata[0]))
        else $error("timer a enable not stored");

    // without the freeze bit a halt must not stop the count
    a_freeze_a: assert property (@(posedge clk) disable iff (srst) // see R07
        (a_run_enable && !cfg_a.debug_freeze) |=> a_count_enable)
        else $error("timer a stalled without freeze");

    b_freeze_a: assert property (@(posedge clk) disable iff (srst) // see R06
        (b_run_enable && !cfg_b.debug_freeze) |=> b_count_enable)
        else $error("timer b stalled without freeze");

    // with the freeze bit a synced halt stops the count
    a_stop_a: assert property (@(posedge clk) disable iff (srst) // see R07
        a_frozen_s |=> !a_count_enable)
        else $error("timer a counts while frozen");

    b_edge_a: assert property (@(posedge clk) disable iff (srst) // see R03
        ctrl_write_s |=> cfg_b.edge_select == $past(avs_writedata[11:10]))
        else $error("timer b edge field wrong");

    a_edge_a: assert property (@(posedge clk) disable iff (srst) // see R04
        ctrl_write_s |=> cfg_a.edge_select == $past(avs_writedata[3:2]))
        else $error("timer a edge field wrong");

    a_invert_a: assert property (@(posedge clk) disable iff (srst) // see R02
        ctrl_write_s |=> cfg_a.output_invert == $past(avs_writedata[6]))
        else $error("timer a invert not stored");

    b_invert_a: assert property (@(posedge clk) disable iff (srst) // see R01
        ctrl_write_s |=> cfg_b.output_invert == $past(avs_writedata[14]))
        else $error("timer b invert not stored");

    mode_out_a: assert property (@(posedge clk) disable iff (srst) // see R11
        config_write_s |=> timer_mode == $past(avs_writedata[2:0]))
        else $error("mode not stored");

    // the control word read back is the one held at capture
    ctrl_read_a: assert property (@(posedge clk) disable iff (srst) // see R10
        ctrl_read_s |=> avs_readdata == $past(st.timer_control_reg))
        else $error("control readback wrong");

    // one wait cycle, then the answer
    bus_ack_a: assert property (@(posedge clk) disable iff (srst)
        bus_pending_s |=> !avs_waitrequest)
        else $error("no answer within one cycle");

    // the answer stands for one cycle only
    wait_high_a: assert property (@(posedge clk) disable iff (srst)
        bus_answer_s |=> avs_waitrequest)
        else $error("answer held too long");
endmodule : dtc_top

/* File: tb/tb_top.sv */
// self-checking testbench of the dual timer control register block
`timescale 1ns/1ps
module tb_top;

    // =====================================================================
    // stimulus and observed signals
    // =====================================================================
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic debug_halt = 1'b0;
    logic pwm_a_raw = 1'b0;
    logic pwm_b_raw = 1'b0;
    logic pwm_a;
    logic pwm_b;
    logic a_count_enable;
    logic b_count_enable;
    logic a_run_enable;
    logic b_run_enable;
    logic [2:0] timer_mode;
    logic irq;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    // 100 mhz clock
    always
    begin
        #5 clk = ~clk;
    end

    dtc_top dtc_top_i
    (
        .clk(clk),
        .srst(srst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .debug_halt(debug_halt),
        .pwm_a_raw(pwm_a_raw),
        .pwm_b_raw(pwm_b_raw),
        .pwm_a(pwm_a),
        .pwm_b(pwm_b),
        .a_count_enable(a_count_enable),
        .b_count_enable(b_count_enable),
        .a_run_enable(a_run_enable),
        .b_run_enable(b_run_enable),
        .timer_mode(timer_mode),
        .irq(irq)
    );

    // =====================================================================
    // reporting
    // =====================================================================
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // =====================================================================
    // avalon-mm master; entered and left on a rising edge
    // =====================================================================
    // no wait limit here: only the hang guard ends a wait
    task automatic bus_wait();
        do
        begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
    endtask : bus_wait

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
        // one idle edge so the strobe is never driven twice in a time step
        @(posedge clk);
        cmp_bit("write answer ends", 1'b1, avs_waitrequest);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        bus_wait();
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
        cmp_bit("read answer ends", 1'b1, avs_waitrequest);
    endtask : bus_rd

    task automatic rd_cmp(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        cmp_word(what, exp, d);
    endtask : rd_cmp

    // =====================================================================
    // scenarios
    // =====================================================================
    // reset state: control zero, everything disabled
    task automatic t_reset();
        rd_cmp("ctrl reset", dtc_pkg::ctrl_offset, 32'h0000_0000);
        rd_cmp("status reset", dtc_pkg::status_offset, 32'h0000_0000);
        cmp_bit("a run reset", 1'b0, a_run_enable);
        cmp_bit("b count reset", 1'b0, b_count_enable);
    endtask : t_reset

    // reserved bits stay zero, enables follow bits 0 and 8, unmapped reads zero
    task automatic t_fields();
        bus_wr(dtc_pkg::ctrl_offset, 32'hffff_ffff);
        rd_cmp("ctrl all ones", dtc_pkg::ctrl_offset, 32'h0000_4f4f);
        cmp_bit("a run set", 1'b1, a_run_enable);
        cmp_bit("b run set", 1'b1, b_run_enable);
        bus_wr(dtc_pkg::ctrl_offset, 32'h0000_0100);
        rd_cmp("ctrl b only", dtc_pkg::ctrl_offset, 32'h0000_0100);
        cmp_bit("a run clear", 1'b0, a_run_enable);
        cmp_bit("b run only", 1'b1, b_run_enable);
        rd_cmp("unmapped", 8'h40, 32'h0000_0000);
        bus_wr(dtc_pkg::config_offset, 32'hffff_fffd);
        cmp_word("mode", 32'h0000_0005, {29'h0, timer_mode});
        rd_cmp("config readback", dtc_pkg::config_offset, 32'h0000_0005);
    endtask : t_fields

    // freeze only matters while the core is halted
    task automatic t_freeze();
        bus_wr(dtc_pkg::ctrl_offset, 32'h0000_0101);
        debug_halt <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit("a count halted no freeze", 1'b1, a_count_enable);
        cmp_bit("b count halted no freeze", 1'b1, b_count_enable);
        bus_wr(dtc_pkg::ctrl_offset, 32'h0000_0303);
        repeat (2) @(posedge clk);
        cmp_bit("a count frozen", 1'b0, a_count_enable);
        cmp_bit("b count frozen", 1'b0, b_count_enable);
        debug_halt <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_bit("a count running", 1'b1, a_count_enable);
        cmp_bit("b count running", 1'b1, b_count_enable);
    endtask : t_freeze

    // one edge code with or without inversion on both halves
    task automatic t_edge(input logic [1:0] c, input logic inv);
        logic [31:0] ctl;
        logic rise;
        logic fall;
        ctl = 32'h0000_0101 | ({30'h0, c} << dtc_pkg::a_edge_lo)
            | ({30'h0, c} << dtc_pkg::b_edge_lo) | ({31'h0, inv} << dtc_pkg::a_invert_pos)
            | ({31'h0, inv} << dtc_pkg::b_invert_pos);
        rise = (c == 2'h0) || (c == 2'h3);
        fall = (c == 2'h1) || (c == 2'h3);
        bus_wr(dtc_pkg::ctrl_offset, ctl);
        bus_wr(dtc_pkg::status_offset, 32'h0000_0003);
        pwm_a_raw <= 1'b1;
        pwm_b_raw <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit("pwm a high", ~inv, pwm_a);
        cmp_bit("pwm b high", ~inv, pwm_b);
        rd_cmp("status rise", dtc_pkg::status_offset, {30'h0, rise, rise});
        bus_wr(dtc_pkg::status_offset, 32'h0000_0003);
        pwm_a_raw <= 1'b0;
        pwm_b_raw <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_bit("pwm a low", inv, pwm_a);
        cmp_bit("pwm b low", inv, pwm_b);
        rd_cmp("status fall", dtc_pkg::status_offset, {30'h0, fall, fall});
    endtask : t_edge

    // masked event keeps irq low; unmasking raises it; clearing drops it
    task automatic t_irq();
        bus_wr(dtc_pkg::mask_offset, 32'h0000_0000);
        bus_wr(dtc_pkg::ctrl_offset, 32'h0000_0001);
        bus_wr(dtc_pkg::status_offset, 32'h0000_0003);
        pwm_a_raw <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit("irq masked", 1'b0, irq);
        bus_wr(dtc_pkg::mask_offset, 32'h0000_0001);
        // the irq flop follows the mask one edge later; the readback gives it time
        rd_cmp("mask readback", dtc_pkg::mask_offset, 32'h0000_0001);
        cmp_bit("irq unmasked", 1'b1, irq);
        bus_wr(dtc_pkg::status_offset, 32'h0000_0001);
        repeat (2) @(posedge clk);
        cmp_bit("irq cleared", 1'b0, irq);
        pwm_a_raw <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : t_irq

    // =====================================================================
    // main sequence
    // =====================================================================
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_fields();
        t_freeze();
        for (int i = 0; i < 8; i++)
            t_edge(i[1:0], i[2]);
        t_irq();
        complete_run();
    end

endmodule : tb_top
